// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, b;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, nbits = 4'h8;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, par_en = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, serial_in, serial_out, got;
	logic [1:0] s_axi_bresp, s_axi_rresp, psel = 2'h0;
	logic [8:0] word, ser_q[$];
	logic [67:0] bus_q[$];
	logic [7:0] rb[4];
	logic [15:0] seed = 16'h1149;
	int failures = 0, samples_checked = 0;
	always #2 clk = ~clk;
	uflfc_top uut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .serial_in, .serial_out);
	uflfc_remote u_rem (.clk, .line_in(serial_out), .line_out(serial_in), .nbits, .par_en, .got,
		.word);
	// ==========================================================
	// Checking
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Compare each answer with the oldest note
	always @(posedge clk) begin
		logic [67:0] n;
		if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready) begin
			n = bus_q.pop_front();
			if (s_axi_rvalid) check("read", {s_axi_rresp, s_axi_rdata} & n[67:34], n[33:0]);
			else check("bresp", {s_axi_bresp, 32'h0}, n[33:0]);
		end
		if (got) check("char", {25'h0, word}, {25'h0, ser_q.pop_front()});
	end
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		print_verdict();
	end
	// ==========================================================
	// Bus and stimulus helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
		bus_q.push_back({34'h3_0000_0000, r, 32'h0});
		@(posedge clk);
		s_axi_awaddr <= {a, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [1:0] r, input logic [31:0] e,
		input logic [31:0] m);
		bus_q.push_back({2'h3, m, r, e});
		@(posedge clk);
		s_axi_araddr <= {a, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask
	// Queue a random byte for sending, noting the frame the far side should see
	task automatic tx();
		logic [7:0] m;
		seed = lfsr(seed);
		m = seed[7:0] & ((8'h01 << nbits) - 8'h01);
		ser_q.push_back(par_en ? {1'h0, m} | ({8'h0, (psel == 2'h0) ? ~^m : (psel == 2'h1) ? ^m
			: ~psel[0]} << nbits) : {1'h0, m});
		wr(6'h00, seed[7:0], 2'h0);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'h1;
		rd(6'h02, 2'h0, 32'hC1, 32'hFFFFFFFF);
		rd(6'h03, 2'h0, 32'h03, 32'hFFFFFFFF);
		rd(6'h09, 2'h0, 32'h0, 32'h4);
		rd(6'h05, 2'h2, 32'h0, 32'hFFFFFFFF);
		wr(6'h05, 8'h00, 2'h2);
		wr(6'h03, 8'h83, 2'h0);
		wr(6'h00, 8'h5A, 2'h0);
		rd(6'h00, 2'h0, 32'h5A, 32'hFFFFFFFF);
		wr(6'h00, 8'h01, 2'h0);
		wr(6'h01, 8'h00, 2'h0);
		wr(6'h03, 8'h03, 2'h0);
		rd(6'h01, 2'h0, 32'h0, 32'hFFFFFFFF);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			nbits <= (i < 4) ? 4'(5 + i) : 4'h8;
			par_en <= (i < 4);
			psel <= 2'(i);
			wr(6'h03, (i < 4) ? {2'h0, 2'(i), 1'h1, 1'h0, 2'(i)} : 8'h03, 2'h0);
			tx();
			repeat (220) @(posedge clk);
		end
		wr(6'h03, 8'h43, 2'h0);
		repeat (200) @(posedge clk);
		check("break", {33'h0, serial_out}, 34'h0);
		// two stops delay the next start
		wr(6'h03, 8'h07, 2'h0);
		tx();
		tx();
		@(posedge got);
		repeat (16) @(posedge clk);
		check("stop", {33'h0, serial_out}, 34'h1);
		wr(6'h03, 8'h03, 2'h0);
		$display("test formats done");
		wr(6'h02, 8'h01, 2'h0);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			rb[i] = seed[7:0];
			u_rem.send(rb[i]);
		end
		repeat (20) @(posedge clk);
		rd(6'h09, 2'h0, 32'h407, 32'h3F3F07);
		for (int c = 0; c < 8; c++) begin
			wr(6'h08, {7'h0, c[2]}, 2'h0);
			wr(6'h02, {c[1:0], 6'h01}, 2'h0);
			rd(6'h09, 2'h0, {31'h0, c < 2}, 32'h1);
		end
		rd(6'h00, 2'h0, {24'h0, rb[0]}, 32'hFFFFFFFF);
		wr(6'h08, 8'h00, 2'h0);
		wr(6'h02, 8'h03, 2'h0);
		rd(6'h09, 2'h0, 32'h0, 32'h3F01);
		$display("test receive done");
		wr(6'h08, 8'h01, 2'h0);
		for (int i = 0; i < 34; i++) tx();
		for (int c = 0; c < 4; c++) begin
			wr(6'h02, {2'h0, 2'(c), 4'h1}, 2'h0);
			rd(6'h09, 2'h0, {30'h0, c != 0, 1'h0}, 32'h2);
		end
		repeat (5600) @(posedge clk);
		rd(6'h09, 2'h0, 32'h0, 32'h3F0000);
		// transmit flush keeps only the character in flight
		wr(6'h08, 8'h00, 2'h0);
		tx();
		for (int i = 0; i < 4; i++) begin
			b = 8'(i);
			wr(6'h00, b, 2'h0);
		end
		wr(6'h02, 8'h05, 2'h0);
		rd(6'h09, 2'h0, 32'h0, 32'h3F0000);
		repeat (400) @(posedge clk);
		$display("test transmit done");
		print_verdict();
	end
endmodule // testbench

// [uflfc_fifo.sv]
`timescale 1ns/1ps
module uflfc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32,
	parameter int unsigned CNT_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	uflfc_fifo_if.fifo port
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] count_ff;
	logic push;
	logic pop;

	// Handshakes, full and empty from the count
	assign port.wr_ready = (count_ff != CNT_W'(DEPTH));
	assign port.rd_valid = (count_ff != '0);
	assign port.rd_data = mem_ff[rd_ptr_ff];
	assign port.count = count_ff;
	assign push = port.wr_valid & port.wr_ready;
	assign pop = port.rd_ready & port.rd_valid;

	// ==========================================================
	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= port.wr_data;
		end
	end

	// Pointers and count, flush empties
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else if (port.flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
			end
			if (pop) begin
				rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
			end
			if (push && !pop) begin
				count_ff <= CNT_W'(count_ff + 1'b1);
			end else if (pop && !push) begin
				count_ff <= CNT_W'(count_ff - 1'b1);
			end
		end
	end
endmodule // uflfc_fifo

// [uflfc_fifo_if.sv]
`timescale 1ns/1ps
interface uflfc_fifo_if #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned CNT_W = 6
);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	logic flush;
	logic [CNT_W-1:0] count;

	// User side of the buffer
	modport owner (
		output wr_valid, wr_data, rd_ready, flush,
		input wr_ready, rd_valid, rd_data, count
	);

	// Buffer side
	modport fifo (
		input wr_valid, wr_data, rd_ready, flush,
		output wr_ready, rd_valid, rd_data, count
	);
endinterface // uflfc_fifo_if

// [uflfc_pkg.sv]
package uflfc_pkg;

	// ==========================================================
	// Register map, index times four is the byte address
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned REG_IDX_W = 6;
	localparam logic [5:0] IDX_DATA = 6'h00;
	localparam logic [5:0] IDX_DIV_HI = 6'h01;
	localparam logic [5:0] IDX_FCR = 6'h02;
	localparam logic [5:0] IDX_LCR = 6'h03;
	localparam logic [5:0] IDX_MODE = 6'h08;
	localparam logic [5:0] IDX_STAT = 6'h09;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ISR_NONE = 8'hC1;
	localparam logic [7:0] LCR_RESET = 8'h03;
	localparam logic [15:0] DIV_RESET = 16'h0001;

	// ==========================================================
	// Field positions
	localparam int unsigned FCR_EN_BIT = 0;
	localparam int unsigned FCR_RXFL_BIT = 1;
	localparam int unsigned FCR_TXFL_BIT = 2;
	localparam int unsigned FCR_TXTRG_LSB = 4;
	localparam int unsigned FCR_RXTRG_LSB = 6;
	localparam int unsigned LCR_LEN_LSB = 0;
	localparam int unsigned LCR_STOP_BIT = 2;
	localparam int unsigned LCR_PEN_BIT = 3;
	localparam int unsigned LCR_PSEL_LSB = 4;
	localparam int unsigned LCR_BRK_BIT = 6;
	localparam int unsigned LCR_DLAB_BIT = 7;
	localparam int unsigned MODE_ENH_BIT = 0;
	localparam int unsigned STAT_RXTRG_BIT = 0;
	localparam int unsigned STAT_TXTRG_BIT = 1;
	localparam int unsigned STAT_FEN_BIT = 2;
	localparam int unsigned STAT_RXCNT_LSB = 8;
	localparam int unsigned STAT_TXCNT_LSB = 16;

	// ==========================================================
	// Trigger tables, entry index is the field value
	localparam logic [7:0] TX_TRIG_ENH [4] = '{8'h10, 8'h20, 8'h40, 8'h70};
	localparam logic [7:0] TX_TRIG_STD = 8'h00;
	localparam logic [7:0] RX_TRIG_STD [4] = '{8'h01, 8'h04, 8'h08, 8'h0E};
	localparam logic [7:0] RX_TRIG_ENH [4] = '{8'h0F, 8'h1F, 8'h3F, 8'h6F};

	// ==========================================================
	// Parity selections and bit timing in oversample ticks
	localparam logic [1:0] PAR_ODD = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_MARK = 2'h2;
	localparam logic [4:0] OS_MID = 5'h07;
	localparam logic [4:0] OS_LAST = 5'h0F;
	localparam logic [4:0] STOP_15_LAST = 5'h17;
	localparam logic [4:0] STOP_2_LAST = 5'h1F;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Serial engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_START = 5'b00010,
		ST_DATA = 5'b00100,
		ST_PAR = 5'b01000,
		ST_STOP = 5'b10000
	} uflfc_line_state_type;

endpackage

// [uflfc_remote.sv]
`timescale 1ns/1ps
module uflfc_remote (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out,
	input wire logic [3:0] nbits,
	input wire logic par_en,
	output logic got,
	output logic [8:0] word
);
	initial begin
		line_out = 1'h1;
		got = 1'h0;
		word = 9'h000;
	end
	// Send start, eight bits LSB first, one stop
	task automatic send(input logic [7:0] d);
		logic [9:0] frm;
		frm = {1'h1, d, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= frm[i];
			repeat (15) @(posedge clk);
		end
	endtask
	// Decode at mid bit, drop frames with a low stop bit
	always begin : rx_proc
		logic [8:0] w;
		@(negedge line_in);
		repeat (8) @(posedge clk);
		w = 9'h000;
		for (int i = 0; i < nbits + par_en; i++) begin
			repeat (16) @(posedge clk);
			w[i] = line_in;
		end
		repeat (16) @(posedge clk);
		if (line_in) begin
			word <= w;
			got <= 1'h1;
			@(posedge clk);
			got <= 1'h0;
		end else begin
			wait (line_in);
		end
	end
endmodule // uflfc_remote

// [uflfc_top.sv]
`timescale 1ns/1ps
module uflfc_top #(
	parameter int unsigned FIFO_DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [uflfc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [uflfc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in,
	output logic serial_out
);
	localparam int unsigned CNT_W = $clog2(FIFO_DEPTH) + 1;

	uflfc_fifo_if #(.WIDTH(8), .CNT_W(CNT_W)) tx_if ();
	uflfc_fifo_if #(.WIDTH(8), .CNT_W(CNT_W)) rx_if ();

	// Control registers
	logic [7:0] lcr_ff;
	logic fifo_en_ff;
	logic [1:0] tx_trg_sel_ff;
	logic [1:0] rx_trg_sel_ff;
	logic flush_rx_ff;
	logic flush_tx_ff;
	logic enh_ff;
	logic [15:0] div_ff;
	logic rx_trig_ff;
	logic tx_trig_ff;
	// Bus state
	logic aw_held_ff;
	logic [uflfc_pkg::REG_IDX_W-1:0] aw_idx_ff;
	logic w_held_ff;
	logic [7:0] w_byte_ff;
	logic w_lane0_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	// Baud and serial engines
	logic [15:0] div_cnt_ff;
	logic tick_ff;
	uflfc_pkg::uflfc_line_state_type tx_state_ff;
	logic [4:0] tx_os_ff;
	logic [7:0] tx_shift_ff;
	logic [2:0] tx_bit_ff;
	logic tx_par_ff;
	logic tx_line_ff;
	logic serial_out_ff;
	uflfc_pkg::uflfc_line_state_type rx_state_ff;
	logic [4:0] rx_os_ff;
	logic [7:0] rx_shift_ff;
	logic [2:0] rx_bit_ff;
	logic rx_push_ff;
	logic [7:0] rx_data_ff;

	logic dlab;
	logic [2:0] last_bit;
	logic tx_can_accept;
	logic is_tx_write;
	logic do_write;
	logic ar_take;
	logic [uflfc_pkg::REG_IDX_W-1:0] ar_idx;
	logic rd_pop;
	logic [31:0] rd_word;
	logic rd_err;
	logic [7:0] rx_thr;
	logic [7:0] tx_thr;
	logic tx_par_bit;
	logic [4:0] stop_last;

	// ==========================================================
	// Buffers
	uflfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_tx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.port(tx_if.fifo)
	);
	uflfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_rx_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.port(rx_if.fifo)
	);

	// ==========================================================
	// Decode
	// divisor select
	assign dlab = lcr_ff[uflfc_pkg::LCR_DLAB_BIT];
	assign last_bit = {1'b1, lcr_ff[uflfc_pkg::LCR_LEN_LSB +: 2]};
	// single holding entry when FIFO mode is off
	assign tx_can_accept = fifo_en_ff ? tx_if.wr_ready : (tx_if.count == '0);
	assign is_tx_write = (aw_idx_ff == uflfc_pkg::IDX_DATA) & !dlab & w_lane0_ff;
	// Write stalls while the transmit buffer cannot take the byte
	assign do_write = aw_held_ff & w_held_ff & !bvalid_ff & !(is_tx_write & !tx_can_accept);
	assign ar_take = s_axi_arvalid & arready_ff;
	assign ar_idx = s_axi_araddr[uflfc_pkg::REG_IDX_W+1:2];
	assign rd_pop = ar_take & (ar_idx == uflfc_pkg::IDX_DATA) & !dlab & rx_if.rd_valid;

	// FIFO connections
	assign tx_if.wr_valid = do_write & is_tx_write;
	assign tx_if.wr_data = w_byte_ff;
	assign tx_if.rd_ready = tick_ff & (tx_state_ff == uflfc_pkg::ST_IDLE);
	assign tx_if.flush = flush_tx_ff;
	assign rx_if.wr_valid = rx_push_ff & (fifo_en_ff | (rx_if.count == '0));
	assign rx_if.wr_data = rx_data_ff;
	assign rx_if.rd_ready = rd_pop;
	assign rx_if.flush = flush_rx_ff;

	assign tx_thr = enh_ff ? uflfc_pkg::TX_TRIG_ENH[tx_trg_sel_ff] : uflfc_pkg::TX_TRIG_STD;
	// standard receive trigger, enhanced receive trigger
	assign rx_thr = enh_ff ? uflfc_pkg::RX_TRIG_ENH[rx_trg_sel_ff]
		: uflfc_pkg::RX_TRIG_STD[rx_trg_sel_ff];

	// ==========================================================
	// Read data mux
	always_comb begin
		rd_word = '0;
		rd_err = 1'b0;
		case (ar_idx)
			uflfc_pkg::IDX_DATA: begin
				rd_word[7:0] = dlab ? div_ff[7:0] : (rx_if.rd_valid ? rx_if.rd_data : 8'h00);
			end
			uflfc_pkg::IDX_DIV_HI: begin
				rd_word[7:0] = dlab ? div_ff[15:8] : 8'h00;
			end
			uflfc_pkg::IDX_FCR: rd_word[7:0] = uflfc_pkg::ISR_NONE;
			uflfc_pkg::IDX_LCR: rd_word[7:0] = lcr_ff;
			uflfc_pkg::IDX_MODE: rd_word[uflfc_pkg::MODE_ENH_BIT] = enh_ff;
			uflfc_pkg::IDX_STAT: begin
				rd_word[uflfc_pkg::STAT_RXTRG_BIT] = rx_trig_ff;
				rd_word[uflfc_pkg::STAT_TXTRG_BIT] = tx_trig_ff;
				rd_word[uflfc_pkg::STAT_FEN_BIT] = fifo_en_ff;
				rd_word[uflfc_pkg::STAT_RXCNT_LSB +: CNT_W] = rx_if.count;
				rd_word[uflfc_pkg::STAT_TXCNT_LSB +: CNT_W] = tx_if.count;
			end
			default: rd_err = 1'b1;
		endcase
	end

	// ==========================================================
	// Write address and data channels, taken in either order
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_ff <= 1'b0;
			aw_idx_ff <= '0;
			awready_ff <= 1'b1;
			w_held_ff <= 1'b0;
			w_byte_ff <= 8'h00;
			w_lane0_ff <= 1'b0;
			wready_ff <= 1'b1;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_held_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr[uflfc_pkg::REG_IDX_W+1:2];
				awready_ff <= 1'b0;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_held_ff <= 1'b1;
				w_byte_ff <= s_axi_wdata[7:0];
				w_lane0_ff <= s_axi_wstrb[0];
				wready_ff <= 1'b0;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				wready_ff <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= uflfc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (aw_idx_ff > uflfc_pkg::IDX_LCR && aw_idx_ff != uflfc_pkg::IDX_MODE
				&& aw_idx_ff != uflfc_pkg::IDX_STAT) ? uflfc_pkg::RESP_SLVERR
				: uflfc_pkg::RESP_OKAY;
		end else if (bvalid_ff && s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Register writes, flush bits clear the cycle after they are set
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lcr_ff <= uflfc_pkg::LCR_RESET;
			fifo_en_ff <= 1'b0;
			tx_trg_sel_ff <= 2'h0;
			rx_trg_sel_ff <= 2'h0;
			flush_rx_ff <= 1'b0;
			flush_tx_ff <= 1'b0;
			enh_ff <= 1'b0;
			div_ff <= uflfc_pkg::DIV_RESET;
		end else begin
			flush_rx_ff <= 1'b0;
			flush_tx_ff <= 1'b0;
			if (do_write && w_lane0_ff) begin
				case (aw_idx_ff)
					uflfc_pkg::IDX_DATA: begin
						if (dlab) begin
							div_ff[7:0] <= w_byte_ff;
						end
					end
					uflfc_pkg::IDX_DIV_HI: begin
						if (dlab) begin
							div_ff[15:8] <= w_byte_ff;
						end
					end
					uflfc_pkg::IDX_FCR: begin
						fifo_en_ff <= w_byte_ff[uflfc_pkg::FCR_EN_BIT];
						flush_rx_ff <= w_byte_ff[uflfc_pkg::FCR_RXFL_BIT];
						flush_tx_ff <= w_byte_ff[uflfc_pkg::FCR_TXFL_BIT];
						tx_trg_sel_ff <= w_byte_ff[uflfc_pkg::FCR_TXTRG_LSB +: 2];
						rx_trg_sel_ff <= w_byte_ff[uflfc_pkg::FCR_RXTRG_LSB +: 2];
					end
					uflfc_pkg::IDX_LCR: lcr_ff <= w_byte_ff;
					uflfc_pkg::IDX_MODE: enh_ff <= w_byte_ff[uflfc_pkg::MODE_ENH_BIT];
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= uflfc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_err ? uflfc_pkg::RESP_SLVERR : uflfc_pkg::RESP_OKAY;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// Trigger status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_trig_ff <= 1'b0;
			tx_trig_ff <= 1'b1;
		end else begin
			rx_trig_ff <= (8'(rx_if.count) >= rx_thr);
			tx_trig_ff <= (8'(tx_if.count) <= tx_thr);
		end
	end

	// ==========================================================
	// Oversample tick, sixteen per bit, divisor zero acts as one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (div_cnt_ff + 16'h0001 >= div_ff) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			div_cnt_ff <= 16'(div_cnt_ff + 16'h0001);
			tick_ff <= 1'b0;
		end
	end

	always_comb begin
		case (lcr_ff[uflfc_pkg::LCR_PSEL_LSB +: 2])
			uflfc_pkg::PAR_ODD: tx_par_bit = ~tx_par_ff;
			uflfc_pkg::PAR_EVEN: tx_par_bit = tx_par_ff;
			uflfc_pkg::PAR_MARK: tx_par_bit = 1'b1;
			default: tx_par_bit = 1'b0;
		endcase
	end

	assign stop_last = !lcr_ff[uflfc_pkg::LCR_STOP_BIT] ? uflfc_pkg::OS_LAST
		: (last_bit == 3'h4) ? uflfc_pkg::STOP_15_LAST : uflfc_pkg::STOP_2_LAST;

	// ==========================================================
	// Transmit engine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_ff <= uflfc_pkg::ST_IDLE;
			tx_os_ff <= '0;
			tx_shift_ff <= 8'h00;
			tx_bit_ff <= '0;
			tx_par_ff <= 1'b0;
			tx_line_ff <= 1'b1;
		end else if (tick_ff) begin
			tx_os_ff <= 5'(tx_os_ff + 1'b1);
			case (tx_state_ff)
				uflfc_pkg::ST_IDLE: begin
					tx_os_ff <= '0;
					if (tx_if.rd_valid) begin
						tx_shift_ff <= tx_if.rd_data;
						// parity over the used bits only
						tx_par_ff <= ^(tx_if.rd_data & (8'hFF >> (3'h7 - last_bit)));
						tx_line_ff <= 1'b0;
						tx_state_ff <= uflfc_pkg::ST_START;
					end
				end
				uflfc_pkg::ST_START: begin
					if (tx_os_ff == uflfc_pkg::OS_LAST) begin
						tx_os_ff <= '0;
						tx_bit_ff <= '0;
						tx_line_ff <= tx_shift_ff[0];
						tx_shift_ff <= tx_shift_ff >> 1;
						tx_state_ff <= uflfc_pkg::ST_DATA;
					end
				end
				uflfc_pkg::ST_DATA: begin
					if (tx_os_ff == uflfc_pkg::OS_LAST) begin
						tx_os_ff <= '0;
						if (tx_bit_ff != last_bit) begin
							tx_bit_ff <= 3'(tx_bit_ff + 1'b1);
							tx_line_ff <= tx_shift_ff[0];
							tx_shift_ff <= tx_shift_ff >> 1;
						end else if (lcr_ff[uflfc_pkg::LCR_PEN_BIT]) begin
							tx_line_ff <= tx_par_bit;
							tx_state_ff <= uflfc_pkg::ST_PAR;
						end else begin
							tx_line_ff <= 1'b1;
							tx_state_ff <= uflfc_pkg::ST_STOP;
						end
					end
				end
				uflfc_pkg::ST_PAR: begin
					if (tx_os_ff == uflfc_pkg::OS_LAST) begin
						tx_os_ff <= '0;
						tx_line_ff <= 1'b1;
						tx_state_ff <= uflfc_pkg::ST_STOP;
					end
				end
				uflfc_pkg::ST_STOP: begin
					if (tx_os_ff >= stop_last) begin // Survives a shortened stop
						tx_state_ff <= uflfc_pkg::ST_IDLE;
					end
				end
				default: tx_state_ff <= uflfc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_out_ff <= 1'b1;
		end else begin
			serial_out_ff <= tx_line_ff & !lcr_ff[uflfc_pkg::LCR_BRK_BIT];
		end
	end

	// ==========================================================
	// Receive engine, samples mid-bit, drops framing errors
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_ff <= uflfc_pkg::ST_IDLE;
			rx_os_ff <= '0;
			rx_shift_ff <= 8'h00;
			rx_bit_ff <= '0;
			rx_push_ff <= 1'b0;
			rx_data_ff <= 8'h00;
		end else begin
			rx_push_ff <= 1'b0;
			if (tick_ff) begin
				rx_os_ff <= 5'(rx_os_ff + 1'b1);
				case (rx_state_ff)
					uflfc_pkg::ST_IDLE: begin
						rx_os_ff <= '0;
						if (!serial_in) begin
							rx_state_ff <= uflfc_pkg::ST_START;
						end
					end
					uflfc_pkg::ST_START: begin
						if (rx_os_ff == uflfc_pkg::OS_MID && serial_in) begin
							rx_state_ff <= uflfc_pkg::ST_IDLE;
						end else if (rx_os_ff == uflfc_pkg::OS_LAST) begin
							rx_os_ff <= '0;
							rx_bit_ff <= '0;
							rx_state_ff <= uflfc_pkg::ST_DATA;
						end
					end
					uflfc_pkg::ST_DATA: begin
						if (rx_os_ff == uflfc_pkg::OS_MID) begin
							rx_shift_ff <= {serial_in, rx_shift_ff[7:1]};
						end else if (rx_os_ff == uflfc_pkg::OS_LAST) begin
							rx_os_ff <= '0;
							rx_bit_ff <= 3'(rx_bit_ff + 1'b1);
							if (rx_bit_ff == last_bit) begin
								rx_state_ff <= lcr_ff[uflfc_pkg::LCR_PEN_BIT]
									? uflfc_pkg::ST_PAR : uflfc_pkg::ST_STOP;
							end
						end
					end
					uflfc_pkg::ST_PAR: begin
						if (rx_os_ff == uflfc_pkg::OS_LAST) begin
							rx_os_ff <= '0;
							rx_state_ff <= uflfc_pkg::ST_STOP;
						end
					end
					uflfc_pkg::ST_STOP: begin
						if (rx_os_ff == uflfc_pkg::OS_MID) begin
							// align short characters to bit 0
							rx_data_ff <= rx_shift_ff >> (3'h7 - last_bit);
							rx_push_ff <= serial_in;
							rx_state_ff <= uflfc_pkg::ST_IDLE;
						end
					end
					default: rx_state_ff <= uflfc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Outputs
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign serial_out = serial_out_ff;
endmodule // uflfc_top

// [uflfc_top_props.sv]
`timescale 1ns/1ps
module uflfc_top_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Handshake steps
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	// Bus timing and blocking
	a_rd_latency: assert property (s_ar_take |=> s_axi_rvalid) else $error("read answer late");
	a_rd_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read answer dropped");
	a_wr_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	a_ready_back: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read ready not back");
	a_rdata_upper: assert property ((s_ar_take and s_axi_araddr[7:2] != 6'h09)
		|=> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
	a_status_pad: assert property ((s_ar_take and s_axi_araddr[7:2] == 6'h09)
		|=> s_axi_rdata[31:22] == 10'h000 && s_axi_rdata[15:14] == 2'h0
		&& s_axi_rdata[7:3] == 5'h00) else $error("status padding set");
	a_unmapped_rd: assert property ((s_ar_take
		and !(s_axi_araddr[7:2] inside {0, 1, 2, 3, 8, 9}))
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("unmapped read answer");
	a_status_read: assert property ((s_ar_take and s_axi_araddr[7:2] == 6'h02)
		|=> s_axi_rdata == 32'h000000C1 && s_axi_rresp == 2'h0) else $error("status read value");
endmodule // uflfc_top_props
bind uflfc_top uflfc_top_props u_props (.clk, .reset_n, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
